// ### clock_out_map.vh
`ifndef CLOCK_OUT_MAP_VH
`define CLOCK_OUT_MAP_VH
// ****************************************
// Register addresses
// ****************************************
`define ADDR_IRQ_ENABLE_CLOCK_OUT 8'h8f
`define ADDR_CLOCK_DIVIDER_CONTROL 8'h97
`define ADDR_TIMER_PAIR_MODE 8'hd1
// ****************************************
// Field positions
// ****************************************
`define BIT_TIMER_B_RUN 7
`define BIT_TIMER_B_SOURCE_SELECT 6
`define BIT_TIMER_B_FAST_TICK 5
`define BIT_TIMER_B_CLOCK_OUT_ENABLE 4
`define BIT_TIMER_A_RUN 3
`define BIT_TIMER_A_SOURCE_SELECT 2
`define BIT_TIMER_A_FAST_TICK 1
`define BIT_TIMER_A_CLOCK_OUT_ENABLE 0
`define BIT_MASTER_OUT_SELECT_HI 3
`define BIT_MASTER_OUT_SELECT_MID 7
`define BIT_MASTER_OUT_SELECT_LO 6
// ****************************************
// Reset values and counts
// ****************************************
`define RESET_REG 8'h00
`define RESET_RELOAD 16'h0000
`define SLOW_TICK_DIVIDE 4'hc
`define MSEL_OFF 3'h0
`define MSEL_DIV1 3'h1
`define MSEL_DIV2 3'h2
`define MSEL_DIV4 3'h3
`define MSEL_DIV16 3'h4
`endif

// ### reload_timer.v
`timescale 1ns/1ps
`include "clock_out_map.vh"
module reload_timer #(
   parameter WIDTH = 16
) (
   input wire clock,
   input wire sys_rst,
   input wire run,
   input wire source_select,
   input wire fast_tick,
   input wire clock_out_enable,
   input wire slow_tick,
   input wire ext_pin,
   input wire [WIDTH-1:0] reload,
   output reg [WIDTH-1:0] count_r,
   output reg toggle_r
);
   reg ext_prev_r;
   wire ext_fall;
   wire tick;
   wire overflow;
   // ****************************************
   // Tick source and counter
   // ****************************************
   assign ext_fall = ext_prev_r & ~ext_pin;
   assign tick = source_select ? ext_fall : (fast_tick ? 1'b1 : slow_tick);
   assign overflow = run & tick & (&count_r);
   always @(posedge clock) begin
      if (sys_rst) begin
         ext_prev_r <= 1'b0;
         count_r <= {WIDTH{1'b0}};
         toggle_r <= 1'b0;
      end else begin
         ext_prev_r <= ext_pin;
         if (run && tick) begin
            if (overflow) begin
               count_r <= reload;
            end else begin
               count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
            end
         end
         if (!clock_out_enable) begin
            toggle_r <= 1'b0;
         end else if (overflow) begin
            toggle_r <= ~toggle_r;
         end
      end
   end
endmodule

// ### programmable_clock_output.v
// Behaviour
// - Mode bit 7 runs timer b
// - Bit 6 picks timer b external pulses
// - Bit 5 picks fast or divide-by-12 tick
// - Bit 4 toggles timer b pin per overflow
// - Timer b sixteen bit auto reload
// - Disabled timer b pin carries no toggle
// - Mode bit 3 runs timer a
// - Bit 2 picks timer a external pulses
// - Bit 1 picks fast or divide-by-12 tick
// - Bit 0 gates timer a toggle pin
// - Timer a sixteen bit auto reload
// - Master select split over two registers
// - Select decodes off, 2, 2, 4, 16
// - Select 1 to 4 drives master clock pin
`timescale 1ns/1ps
`include "clock_out_map.vh"
module programmable_clock_output #(
   parameter WIDTH = 16
) (
   input wire clock,
   input wire sys_rst,
   input wire reg_write,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata_r,
   input wire [WIDTH-1:0] timer_a_reload,
   input wire [WIDTH-1:0] timer_b_reload,
   input wire timer_a_ext_pin,
   input wire timer_b_ext_pin,
   output reg timer_a_out_r,
   output reg timer_a_out_en_r,
   output reg timer_b_out_r,
   output reg timer_b_out_en_r,
   output reg master_clock_out_pin,
   output reg master_clock_out_en_r
);
   reg [7:0] irq_enable_clock_out_r;
   reg [7:0] clock_divider_control_r;
   reg [7:0] timer_pair_mode_r;
   reg [3:0] slow_count_r;
   reg slow_tick_r;
   reg [3:0] prescale_r;
   reg master_nxt;
   reg master_en_nxt;
   reg [7:0] reg_rdata_nxt;
   wire [2:0] master_sel;
   wire [1:0] run_bits;
   wire [1:0] source_bits;
   wire [1:0] fast_bits;
   wire [1:0] enable_bits;
   wire [1:0] ext_bits;
   wire [1:0] toggle_bits;
   wire [2*WIDTH-1:0] reload_bits;
   genvar lane;
   // ****************************************
   // Register file
   // ****************************************
   always @(posedge clock) begin
      if (sys_rst) begin
         irq_enable_clock_out_r <= `RESET_REG;
         clock_divider_control_r <= `RESET_REG;
         timer_pair_mode_r <= `RESET_REG;
      end else if (reg_write) begin
         case (reg_addr)
            `ADDR_IRQ_ENABLE_CLOCK_OUT: begin
               irq_enable_clock_out_r <= reg_wdata;
            end
            `ADDR_CLOCK_DIVIDER_CONTROL: begin
               clock_divider_control_r <= reg_wdata;
            end
            `ADDR_TIMER_PAIR_MODE: begin
               timer_pair_mode_r <= reg_wdata;
            end
            default: begin
            end
         endcase
      end
   end
   // ****************************************
   // Read back
   // ****************************************
   always @* begin
      case (reg_addr)
         `ADDR_IRQ_ENABLE_CLOCK_OUT: begin
            reg_rdata_nxt = irq_enable_clock_out_r;
         end
         `ADDR_CLOCK_DIVIDER_CONTROL: begin
            reg_rdata_nxt = clock_divider_control_r;
         end
         `ADDR_TIMER_PAIR_MODE: begin
            reg_rdata_nxt = timer_pair_mode_r;
         end
         default: begin
            reg_rdata_nxt = 8'h00;
         end
      endcase
   end
   always @(posedge clock) begin
      if (sys_rst) begin
         reg_rdata_r <= 8'h00;
      end else begin
         reg_rdata_r <= reg_rdata_nxt;
      end
   end
   // ****************************************
   // Divide-by-12 tick
   // ****************************************
   always @(posedge clock) begin
      if (sys_rst) begin
         slow_count_r <= 4'h0;
         slow_tick_r <= 1'b0;
      end else if (slow_count_r == `SLOW_TICK_DIVIDE - 4'h1) begin
         slow_count_r <= 4'h0;
         slow_tick_r <= 1'b1;
      end else begin
         slow_count_r <= slow_count_r + 4'h1;
         slow_tick_r <= 1'b0;
      end
   end
   // ****************************************
   // Timer lanes, index 0 is timer a
   // ****************************************
   assign run_bits = {
      timer_pair_mode_r[`BIT_TIMER_B_RUN],
      timer_pair_mode_r[`BIT_TIMER_A_RUN]};
   assign source_bits = {
      timer_pair_mode_r[`BIT_TIMER_B_SOURCE_SELECT],
      timer_pair_mode_r[`BIT_TIMER_A_SOURCE_SELECT]};
   assign fast_bits = {
      timer_pair_mode_r[`BIT_TIMER_B_FAST_TICK],
      timer_pair_mode_r[`BIT_TIMER_A_FAST_TICK]};
   assign enable_bits = {
      timer_pair_mode_r[`BIT_TIMER_B_CLOCK_OUT_ENABLE],
      timer_pair_mode_r[`BIT_TIMER_A_CLOCK_OUT_ENABLE]};
   assign ext_bits = {timer_b_ext_pin, timer_a_ext_pin};
   assign reload_bits = {timer_b_reload, timer_a_reload};
   generate
      for (lane = 0; lane < 2; lane = lane + 1) begin : timer_lane
         reload_timer #(
            .WIDTH(WIDTH)
         ) reload_timer_i (
            .clock(clock),
            .sys_rst(sys_rst),
            .run(run_bits[lane]),
            .source_select(source_bits[lane]),
            .fast_tick(fast_bits[lane]),
            .clock_out_enable(enable_bits[lane]),
            .slow_tick(slow_tick_r),
            .ext_pin(ext_bits[lane]),
            .reload(reload_bits[lane*WIDTH +: WIDTH]),
            .count_r(),
            .toggle_r(toggle_bits[lane])
         );
      end
   endgenerate
   // ****************************************
   // Timer pins
   // ****************************************
   always @(posedge clock) begin
      if (sys_rst) begin
         timer_a_out_r <= 1'b0;
         timer_a_out_en_r <= 1'b1;
         timer_b_out_r <= 1'b0;
         timer_b_out_en_r <= 1'b1;
      end else begin
         timer_a_out_r <= toggle_bits[0];
         timer_a_out_en_r <= ~enable_bits[0];
         timer_b_out_r <= toggle_bits[1];
         timer_b_out_en_r <= ~enable_bits[1];
      end
   end
   // ****************************************
   // Master clock output
   // ****************************************
   assign master_sel = {
      irq_enable_clock_out_r[`BIT_MASTER_OUT_SELECT_HI],
      clock_divider_control_r[`BIT_MASTER_OUT_SELECT_MID],
      clock_divider_control_r[`BIT_MASTER_OUT_SELECT_LO]};
   always @(posedge clock) begin
      if (sys_rst) begin
         prescale_r <= 4'h0;
      end else begin
         prescale_r <= prescale_r + 4'h1;
      end
   end
   // ****************************************
   // Master select decode
   // ****************************************
   always @* begin
      case (master_sel)
         `MSEL_DIV1: begin
            master_nxt = ~master_clock_out_pin;
            master_en_nxt = 1'b0;
         end
         `MSEL_DIV2: begin
            master_nxt = prescale_r[0];
            master_en_nxt = 1'b0;
         end
         `MSEL_DIV4: begin
            master_nxt = prescale_r[1];
            master_en_nxt = 1'b0;
         end
         `MSEL_DIV16: begin
            master_nxt = prescale_r[3];
            master_en_nxt = 1'b0;
         end
         default: begin
            master_nxt = 1'b0;
            master_en_nxt = 1'b1;
         end
      endcase
   end
   always @(posedge clock) begin
      if (sys_rst) begin
         master_clock_out_pin <= 1'b0;
         master_clock_out_en_r <= 1'b1;
      end else begin
         master_clock_out_pin <= master_nxt;
         master_clock_out_en_r <= master_en_nxt;
      end
   end
endmodule

// ### clock_out_assertions.sv
`timescale 1ns/1ps
`include "clock_out_map.vh"
// ****
// Pin output checks
// ****
module clock_out_assertions (
   input wire clock,
   input wire sys_rst,
   input wire reg_write,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire timer_a_out_r,
   input wire timer_a_out_en_r,
   input wire timer_b_out_r,
   input wire timer_b_out_en_r,
   input wire master_clock_out_pin,
   input wire master_clock_out_en_r
);
   reg [7:0] mode_r;
   reg [7:0] ie_r;
   reg [7:0] cd_r;
   wire [2:0] sel = {ie_r[3], cd_r[7:6]};
   wire m_on = sel != 3'h0 && sel < 3'h5;
   always @(posedge clock) begin
      if (sys_rst) begin
         mode_r <= 8'h00;
         ie_r <= 8'h00;
         cd_r <= 8'h00;
      end else if (reg_write) begin
         case (reg_addr)
            `ADDR_TIMER_PAIR_MODE: mode_r <= reg_wdata;
            `ADDR_IRQ_ENABLE_CLOCK_OUT: ie_r <= reg_wdata;
            `ADDR_CLOCK_DIVIDER_CONTROL: cd_r <= reg_wdata;
            default: ;
         endcase
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   sequence s_idle(b); (!b && $stable(mode_r)) [*3]; endsequence
   property p_a_en; $stable(mode_r) [*2] |-> timer_a_out_en_r == !mode_r[0];
   endproperty
   a_a_en: assert property (p_a_en) else $error("timer a enable");
   property p_b_en; $stable(mode_r) [*2] |-> timer_b_out_en_r == !mode_r[4];
   endproperty
   a_b_en: assert property (p_b_en) else $error("timer b enable");
   property p_a_low; timer_a_out_en_r [*3] |-> !timer_a_out_r; endproperty
   a_a_low: assert property (p_a_low) else $error("timer a low");
   property p_b_low; timer_b_out_en_r [*3] |-> !timer_b_out_r; endproperty
   a_b_low: assert property (p_b_low) else $error("timer b low");
   property p_a_stop; s_idle(mode_r[3]) |-> $stable(timer_a_out_r); endproperty
   a_a_stop: assert property (p_a_stop) else $error("timer a moved");
   property p_b_stop; s_idle(mode_r[7]) |-> $stable(timer_b_out_r); endproperty
   a_b_stop: assert property (p_b_stop) else $error("timer b moved");
   property p_m_en; $stable(sel) [*2] |-> master_clock_out_en_r == !m_on;
   endproperty
   a_m_en: assert property (p_m_en) else $error("master enable");
   property p_div2;
      (sel == 3'h2) [*3] |->
         master_clock_out_pin != $past(master_clock_out_pin);
   endproperty
   a_div2: assert property (p_div2) else $error("master half rate");
endmodule

// ### tb_programmable_clock_output.sv
`timescale 1ns/1ps
`include "clock_out_map.vh"
module tb_programmable_clock_output;
   reg clock = 0;
   reg sys_rst = 1;
   reg reg_write = 0;
   reg [7:0] reg_addr = 8'h00;
   reg [7:0] reg_wdata = 8'h00;
   reg [15:0] ra = 16'hfff0;
   reg [15:0] rb = 16'hfff8;
   reg ext = 0;
   wire [7:0] rd_q;
   wire a_o, a_e, b_o, b_e, m_o, m_e;
   wire [2:0] outs = {m_o, b_o, a_o};
   integer err_count = 0;
   integer num_checks = 0;
   integer n;
   integer i;
   initial forever #50 clock = ~clock;
   always @(negedge clock) ext <= ~ext;
   programmable_clock_output programmable_clock_output_i (.clock(clock),
      .sys_rst(sys_rst), .reg_write(reg_write), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata_r(rd_q), .timer_a_reload(ra),
      .timer_b_reload(rb), .timer_a_ext_pin(ext), .timer_b_ext_pin(ext),
      .timer_a_out_r(a_o), .timer_a_out_en_r(a_e), .timer_b_out_r(b_o),
      .timer_b_out_en_r(b_e), .master_clock_out_pin(m_o),
      .master_clock_out_en_r(m_e));
   task tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task chk(input string s, input [16:0] e, input [16:0] g);
      num_checks = num_checks + 1;
      if (g !== e) begin
         err_count = err_count + 1;
         $display("unexpected %s expected %h seen %h", s, e, g);
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      @(negedge clock);
      reg_write = 1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clock);
      reg_write = 0;
   endtask
   task rd(input [7:0] a, input [7:0] e);
      @(negedge clock);
      reg_addr = a;
      @(negedge clock);
      chk("read data", {9'h000, e}, {9'h000, rd_q});
   endtask
   // ****
   // Cycles between two output changes
   // ****
   task gap(input integer w);
      reg p;
      integer k;
      integer j;
      k = 0;
      for (j = 0; j < 2; j = j + 1) begin
         p = outs[w];
         n = 0;
         while (outs[w] === p && k < 70000) begin
            @(negedge clock);
            k = k + 1;
            n = n + 1;
         end
      end
      if (k >= 70000) begin
         err_count = err_count + 1;
         $display("unexpected output change expected 1 seen 0");
         tally_and_finish;
      end
   endtask
   task t_regs;
      rd(`ADDR_TIMER_PAIR_MODE, 8'h00);
      rd(`ADDR_CLOCK_DIVIDER_CONTROL, 8'h00);
      chk("pin enables", 3'h7, {a_e, b_e, m_e});
      wr(`ADDR_IRQ_ENABLE_CLOCK_OUT, 8'h08);
      rd(`ADDR_IRQ_ENABLE_CLOCK_OUT, 8'h08);
      wr(8'h10, 8'hff);
      rd(8'h10, 8'h00);
      wr(`ADDR_IRQ_ENABLE_CLOCK_OUT, 8'h00);
      $display("test registers done");
   endtask
   task t_timers;
      wr(`ADDR_TIMER_PAIR_MODE, 8'hbb);
      rd(`ADDR_TIMER_PAIR_MODE, 8'hbb);
      gap(0);
      chk("timer a fast", 17'h1_0000 - ra, n[16:0]);
      gap(1);
      chk("timer b fast", 17'h1_0000 - rb, n[16:0]);
      wr(`ADDR_TIMER_PAIR_MODE, 8'hb9);
      gap(0);
      chk("timer a slow", (17'h1_0000 - ra) * 4'hc, n[16:0]);
      wr(`ADDR_TIMER_PAIR_MODE, 8'hff);
      gap(0);
      chk("timer a pulses", (17'h1_0000 - ra) * 2'h2, n[16:0]);
      gap(1);
      chk("timer b pulses", (17'h1_0000 - rb) * 2'h2, n[16:0]);
      $display("test timers done");
   endtask
   task t_stop;
      reg [1:0] s;
      wr(`ADDR_TIMER_PAIR_MODE, 8'h11);
      repeat (3) @(negedge clock);
      s = outs[1:0];
      repeat (200) @(negedge clock);
      chk("stopped outputs", s, outs[1:0]);
      chk("driving enables", 2'h0, {a_e, b_e});
      wr(`ADDR_TIMER_PAIR_MODE, 8'h00);
      repeat (3) @(negedge clock);
      chk("disabled pins", 4'hc, {a_e, b_e, a_o, b_o});
      $display("test stop done");
   endtask
   task t_master;
      for (i = 1; i < 5; i = i + 1) begin
         wr(`ADDR_IRQ_ENABLE_CLOCK_OUT, {4'h0, i[2], 3'h0});
         wr(`ADDR_CLOCK_DIVIDER_CONTROL, {i[1:0], 6'h00});
         rd(`ADDR_CLOCK_DIVIDER_CONTROL, {i[1:0], 6'h00});
         gap(2);
         chk("master gap", i == 4 ? 4'h8 : (i == 3 ? 2'h2 : 1'h1),
            n[16:0]);
         chk("master enable", 1'h0, m_e);
      end
      wr(`ADDR_CLOCK_DIVIDER_CONTROL, 8'h40);
      repeat (3) @(negedge clock);
      chk("master reserved", 2'h2, {m_e, m_o});
      wr(`ADDR_IRQ_ENABLE_CLOCK_OUT, 8'h00);
      wr(`ADDR_CLOCK_DIVIDER_CONTROL, 8'h00);
      repeat (3) @(negedge clock);
      chk("master off", 2'h2, {m_e, m_o});
      $display("test master done");
   endtask
   initial begin
      repeat (16) @(negedge clock);
      sys_rst = 0;
      t_regs;
      t_timers;
      t_stop;
      t_master;
      tally_and_finish;
   end
endmodule
bind programmable_clock_output clock_out_assertions
   clock_out_assertions_i (.*);
